// ===== rtl/aopc_gain_dec.sv
// Purpose: Two-bit mixer gain code to attenuation in tenths of a dB
// Assumes: Code comes from a register field, through the bridged-mode select for the right line path
// Notes:   Pure combinational
`timescale 1ns/10ps
module aopc_gain_dec
  import aopc_pkg::*;
(
  input  wire logic [1:0] code,
  output logic      [7:0] attTenthDb
);
  always_comb begin
    case (code)
      2'h0:    attTenthDb = ATT_00;
      2'h1:    attTenthDb = ATT_01;
      2'h2:    attTenthDb = ATT_10;
      default: attTenthDb = ATT_11;
    endcase
  end
endmodule

// ===== rtl/aopc_pkg.sv
// Purpose: Shared constants for the audio output path control block
// Assumes: APB register slave, 25 MHz sys_clk
// Notes:   Printed offsets are register indexes; byte address is index times four
package aopc_pkg;
  localparam int          CLK_MHZ          = 25;
  localparam int          ADDR_W           = 10;
  localparam logic [7:0] IDX_HP_MIX_L     = 8'h29;
  localparam logic [7:0] IDX_HP_MIX_R     = 8'h2a;
  localparam logic [7:0] IDX_HP_SEL_GAIN  = 8'h2b;
  localparam logic [7:0] IDX_SPK_MIX_L    = 8'h2e;
  localparam logic [7:0] IDX_SPK_MIX_R    = 8'h2f;
  localparam logic [7:0] IDX_SPK_GAIN     = 8'h30;
  localparam logic [7:0] IDX_SPK_VOL_L    = 8'h31;
  localparam logic [7:0] IDX_SPK_VOL_R    = 8'h32;
  localparam logic [7:0] IDX_LINE_MIX_L   = 8'h37;
  localparam logic [7:0] IDX_LINE_GAIN_L  = 8'h38;
  localparam logic [7:0] IDX_LINE_VOL_L   = 8'h39;
  localparam logic [7:0] IDX_LINE_MIX_R   = 8'h3a;
  localparam logic [7:0] IDX_LINE_GAIN_R  = 8'h3b;
  localparam logic [7:0] IDX_LINE_VOL_R   = 8'h3c;
  localparam logic [7:0] MASK_SRC         = 8'h3f;
  localparam logic [7:0] MASK_SRC_MODE    = 8'h7f;
  localparam logic [7:0] MASK_LINE_MODE   = 8'hbf;
  localparam logic [7:0] MASK_GAIN1       = 8'h03;
  localparam logic [7:0] MASK_GAIN2       = 8'h0f;
  localparam logic [7:0] MASK_HP_SEL_GAIN = 8'h3f;
  localparam logic [7:0] MASK_LINE_VOL    = 8'h9f;
  localparam logic [7:0] MASK_SPK_VOL     = 8'hbf;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_LINE_VOL     = 8'h15;
  localparam logic [7:0] RST_SPK_VOL      = 8'h2c;
  localparam int          BIT_MODE         = 7;
  localparam int          BIT_FOLLOW       = 6;
  localparam int          BIT_MUTE         = 7;
  localparam int          BIT_HP_SEL_R     = 5;
  localparam int          BIT_HP_SEL_L     = 4;
  localparam int          TRIP_MAX_NS      = 1000;
  localparam int          RETRY_US         = 50;
  localparam int          RETRY_CYC        = RETRY_US * CLK_MHZ;
  localparam int          SYNC_LAT_CYC     = 3;
  localparam int          TRIP_MAX_CYC     = (TRIP_MAX_NS * CLK_MHZ) / 1000;
  // Attenuation in tenths of a dB for each two-bit gain code
  localparam logic [7:0] ATT_00 = 8'h00;
  localparam logic [7:0] ATT_01 = 8'h3c;
  localparam logic [7:0] ATT_10 = 8'h5f;
  localparam logic [7:0] ATT_11 = 8'h78;
endpackage

// ===== rtl/aopc_spk_guard.sv
// Purpose: Thermal short-circuit shutdown and timed retry for one speaker
// Assumes: Fault input is asynchronous to sys_clk
// Notes:   Output enable drops combinationally once the fault is qualified
`timescale 1ns/10ps
module aopc_spk_guard
  import aopc_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC
)(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic enableReq,
  input  wire logic thermFault,
  output logic      spkEnable,
  output logic      shutActive
);
  typedef enum logic [0:0] {ST_RUN, ST_HOLD} aopc_guard_e;
  initial begin
    if (RETRY_CYCLES < 2) $error("RETRY_CYCLES too small");
    if (SYNC_LAT_CYC >= TRIP_MAX_CYC) $error("Fault path slower than trip limit");
  end
  logic [2:0]  syncReg;
  logic        faultReg;
  aopc_guard_e stateReg;
  logic [$clog2(RETRY_CYCLES+1)-1:0] cntReg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncReg <= 3'h0;
    end else begin
      syncReg <= {syncReg[1:0], thermFault};
    end
  end
  // Level accepted only once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultReg <= 1'b0;
    end else if (syncReg[1] == syncReg[2]) begin
      faultReg <= syncReg[2];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ST_RUN;
      cntReg   <= '0;
    end else begin
      case (stateReg)
        ST_RUN: begin
          if (faultReg) begin
            stateReg <= ST_HOLD;
            cntReg   <= '0;
          end
        end
        default: begin
          if (cntReg == ($bits(cntReg))'(RETRY_CYCLES - 1)) begin
            stateReg <= ST_RUN;
          end else begin
            cntReg <= cntReg + 1'b1;
          end
        end
      endcase
    end
  end
  // Retry re-enables; a lingering fault trips again next cycle
  assign spkEnable  = enableReq && (stateReg == ST_RUN) && !faultReg;
  assign shutActive = (stateReg == ST_HOLD);
endmodule

// ===== rtl/aopc_top.sv
// Purpose: Register bank steering the analog output paths of the codec
// Assumes: APB slave, byte address is four times the register index
// Notes:   Unmapped addresses read zero and answer with pslverr
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module aopc_top
  import aopc_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC
)(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              spkLeftEnableReq,
  input  wire logic              spkRightEnableReq,
  input  wire logic              thermFaultLeft,
  input  wire logic              thermFaultRight,
  output logic                   lineBridged,
  output logic      [5:0]        lineLeftSources,
  output logic      [5:0]        lineRightSources,
  output logic      [7:0]        lineLeftAtt,
  output logic      [7:0]        lineRightAtt,
  output logic      [4:0]        lineLeftVolCode,
  output logic      [4:0]        lineRightVolCode,
  output logic                   lineLeftMute,
  output logic                   lineRightMute,
  output logic      [5:0]        spkLeftSources,
  output logic      [5:0]        spkRightSources,
  output logic      [7:0]        spkLeftAtt,
  output logic      [7:0]        spkRightAtt,
  output logic      [5:0]        spkLeftVolCode,
  output logic      [5:0]        spkRightVolCode,
  output logic                   spkLeftMute,
  output logic                   spkRightMute,
  output logic                   spkLeftEnable,
  output logic                   spkRightEnable,
  output logic                   spkRightClockFromLeft,
  output logic                   spkLeftShutdown,
  output logic                   spkRightShutdown,
  output logic      [5:0]        hpLeftSources,
  output logic      [5:0]        hpRightSources,
  output logic      [7:0]        hpLeftAtt,
  output logic      [7:0]        hpRightAtt,
  output logic                   hpLeftFromMixer,
  output logic                   hpRightFromMixer
);
  localparam int NREG = 14;
  // Index of each entry, in field-view order
  localparam logic [7:0] REG_IDX [NREG] = '{
    IDX_HP_MIX_L,
    IDX_HP_MIX_R,
    IDX_HP_SEL_GAIN,
    IDX_SPK_MIX_L,
    IDX_SPK_MIX_R,
    IDX_SPK_GAIN,
    IDX_SPK_VOL_L,
    IDX_SPK_VOL_R,
    IDX_LINE_MIX_L,
    IDX_LINE_GAIN_L,
    IDX_LINE_VOL_L,
    IDX_LINE_MIX_R,
    IDX_LINE_GAIN_R,
    IDX_LINE_VOL_R
  };
  // Bit 6 of the right speaker mixer is the clock follow bit
  localparam logic [7:0] REG_MASK [NREG] = '{
    MASK_SRC,
    MASK_SRC,
    MASK_HP_SEL_GAIN,
    MASK_SRC,
    MASK_SRC_MODE,
    MASK_GAIN2,
    MASK_SPK_VOL,
    MASK_SPK_VOL,
    MASK_SRC,
    MASK_GAIN1,
    MASK_LINE_VOL,
    MASK_LINE_MODE,
    MASK_GAIN1,
    MASK_LINE_VOL
  };
  // Values loaded while rst_n is low
  localparam logic [7:0] REG_RST [NREG] = '{
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_SPK_VOL,
    RST_SPK_VOL,
    RST_ZERO,
    RST_ZERO,
    RST_LINE_VOL,
    RST_ZERO,
    RST_ZERO,
    RST_LINE_VOL
  };

  initial begin
    if (ADDR_W < 8) $error("ADDR_W too narrow for register map");
  end

  logic [7:0] regFile [NREG];
  logic [NREG-1:0] hitVec;
  logic       anyHit;
  logic       wordAligned;
  logic [7:0] regIndex;
  logic [7:0] readByte;
  logic       accessPhase;

  assign wordAligned = (paddr[1:0] == 2'h0);
  assign regIndex    = 8'(paddr[ADDR_W-1:2]);
  assign accessPhase = psel && penable;

  // One register per entry: address match, masked write, reset value
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hitVec[gi] = wordAligned && (regIndex == REG_IDX[gi]);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          regFile[gi] <= REG_RST[gi];
        end else if (accessPhase && pwrite && hitVec[gi] && pstrb[0]) begin
          regFile[gi] <= pwdata[7:0] & REG_MASK[gi];
        end
      end
    end
  endgenerate

  assign anyHit = |hitVec;

  // Word decode; unaligned or unmapped words read zero
  always_comb begin
    if (!wordAligned) begin
      readByte = 8'h00;
    end else if (regIndex == IDX_HP_MIX_L) begin
      readByte = regFile[0];
    end else if (regIndex == IDX_HP_MIX_R) begin
      readByte = regFile[1];
    end else if (regIndex == IDX_HP_SEL_GAIN) begin
      readByte = regFile[2];
    end else if (regIndex == IDX_SPK_MIX_L) begin
      readByte = regFile[3];
    end else if (regIndex == IDX_SPK_MIX_R) begin
      readByte = regFile[4];
    end else if (regIndex == IDX_SPK_GAIN) begin
      readByte = regFile[5];
    end else if (regIndex == IDX_SPK_VOL_L) begin
      readByte = regFile[6];
    end else if (regIndex == IDX_SPK_VOL_R) begin
      readByte = regFile[7];
    end else if (regIndex == IDX_LINE_MIX_L) begin
      readByte = regFile[8];
    end else if (regIndex == IDX_LINE_GAIN_L) begin
      readByte = regFile[9];
    end else if (regIndex == IDX_LINE_VOL_L) begin
      readByte = regFile[10];
    end else if (regIndex == IDX_LINE_MIX_R) begin
      readByte = regFile[11];
    end else if (regIndex == IDX_LINE_GAIN_R) begin
      readByte = regFile[12];
    end else if (regIndex == IDX_LINE_VOL_R) begin
      readByte = regFile[13];
    end else begin
      readByte = 8'h00;
    end
  end

  // Zero wait states; ready is combinational so every access takes two cycles
  assign pready  = 1'b1;
  assign pslverr = accessPhase && !anyHit;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h0, readByte};
    end
  end

  // Field views
  logic [7:0] hpMixL;
  logic [7:0] hpMixR;
  logic [7:0] hpSelGain;

  logic [7:0] spkMixL;
  logic [7:0] spkMixR;
  logic [7:0] spkGain;
  logic [7:0] spkVolL;
  logic [7:0] spkVolR;

  logic [7:0] lineMixL;
  logic [7:0] lineGainL;
  logic [7:0] lineVolL;
  logic [7:0] lineMixR;
  logic [7:0] lineGainR;
  logic [7:0] lineVolR;

  assign hpMixL    = regFile[0];
  assign hpMixR    = regFile[1];
  assign hpSelGain = regFile[2];
  assign spkMixL   = regFile[3];
  assign spkMixR   = regFile[4];
  assign spkGain   = regFile[5];
  assign spkVolL   = regFile[6];
  assign spkVolR   = regFile[7];
  assign lineMixL  = regFile[8];
  assign lineGainL = regFile[9];
  assign lineVolL  = regFile[10];
  assign lineMixR  = regFile[11];
  assign lineGainR = regFile[12];
  assign lineVolR  = regFile[13];

  logic       bridged;
  logic [1:0] lineRightGainCode;
  logic [7:0] attLineL;
  logic [7:0] attLineR;
  logic [7:0] attSpkL;
  logic [7:0] attSpkR;
  logic [7:0] attHpL;
  logic [7:0] attHpR;
  logic       guardLeftOn;
  logic       guardRightOn;
  logic       guardLeftShut;
  logic       guardRightShut;

  assign bridged = !lineMixR[BIT_MODE];
  // Bridged mode drives both halves from the left mixer and gain
  assign lineRightGainCode = bridged ? lineGainL[1:0] : lineGainR[1:0];

  aopc_gain_dec u_att_line_l (
    .code       (lineGainL[1:0]),
    .attTenthDb (attLineL)
  );

  aopc_gain_dec u_att_line_r (
    .code       (lineRightGainCode),
    .attTenthDb (attLineR)
  );

  aopc_gain_dec u_att_spk_l (
    .code       (spkGain[1:0]),
    .attTenthDb (attSpkL)
  );

  aopc_gain_dec u_att_spk_r (
    .code       (spkGain[3:2]),
    .attTenthDb (attSpkR)
  );

  aopc_gain_dec u_att_hp_l (
    .code       (hpSelGain[1:0]),
    .attTenthDb (attHpL)
  );

  aopc_gain_dec u_att_hp_r (
    .code       (hpSelGain[3:2]),
    .attTenthDb (attHpR)
  );

  aopc_spk_guard #(
    .RETRY_CYCLES (RETRY_CYCLES)
  ) u_guard_l (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .enableReq  (spkLeftEnableReq),
    .thermFault (thermFaultLeft),
    .spkEnable  (guardLeftOn),
    .shutActive (guardLeftShut)
  );

  aopc_spk_guard #(
    .RETRY_CYCLES (RETRY_CYCLES)
  ) u_guard_r (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .enableReq  (spkRightEnableReq),
    .thermFault (thermFaultRight),
    .spkEnable  (guardRightOn),
    .shutActive (guardRightShut)
  );

  // Line path; volume code passes as is, the analog PGA maps it
  assign lineBridged      = bridged;
  assign lineLeftSources  = lineMixL[5:0];
  assign lineRightSources = bridged ? lineMixL[5:0] : lineMixR[5:0];
  assign lineLeftAtt      = attLineL;
  assign lineRightAtt     = attLineR;
  assign lineLeftVolCode  = lineVolL[4:0];
  assign lineRightVolCode = bridged ? lineVolL[4:0] : lineVolR[4:0];
  assign lineLeftMute     = lineVolL[BIT_MUTE];
  assign lineRightMute    = bridged ? lineVolL[BIT_MUTE] : lineVolR[BIT_MUTE];

  // Speaker path
  assign spkLeftSources   = spkMixL[5:0];
  assign spkRightSources  = spkMixR[5:0];
  assign spkLeftAtt       = attSpkL;
  assign spkRightAtt      = attSpkR;
  assign spkLeftVolCode   = spkVolL[5:0];
  assign spkRightVolCode  = spkVolR[5:0];
  assign spkLeftMute      = spkVolL[BIT_MUTE];
  assign spkRightMute     = spkVolR[BIT_MUTE];
  assign spkLeftEnable    = guardLeftOn;
  assign spkRightEnable   = guardRightOn;
  assign spkLeftShutdown  = guardLeftShut;
  assign spkRightShutdown = guardRightShut;
  // Following only makes sense while both switching stages run
  assign spkRightClockFromLeft = spkMixR[BIT_FOLLOW] && guardLeftOn && guardRightOn;

  // Headphone path
  assign hpLeftSources    = hpMixL[5:0];
  assign hpRightSources   = hpMixR[5:0];
  assign hpLeftAtt        = attHpL;
  assign hpRightAtt       = attHpR;
  assign hpLeftFromMixer  = hpSelGain[BIT_HP_SEL_L];
  assign hpRightFromMixer = hpSelGain[BIT_HP_SEL_R];
endmodule

// ===== tb/aopc_props.sv
// Purpose: Concurrent checks on the output path control register bank
// Assumes: Single sys_clk domain, rst_n asynchronous active low
// Notes:   Attached to aopc_top by the bind at the foot of this file
`timescale 1ns/10ps
module aopc_props
  import aopc_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC
)(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              thermFaultLeft,
  input wire logic              lineBridged,
  input wire logic [5:0]        lineLeftSources,
  input wire logic [5:0]        lineRightSources,
  input wire logic [7:0]        lineLeftAtt,
  input wire logic [7:0]        lineRightAtt,
  input wire logic [4:0]        lineLeftVolCode,
  input wire logic [4:0]        lineRightVolCode,
  input wire logic [5:0]        spkLeftVolCode,
  input wire logic              spkLeftMute,
  input wire logic              spkLeftEnable,
  input wire logic              spkRightEnable,
  input wire logic              spkRightClockFromLeft,
  input wire logic              spkLeftShutdown,
  input wire logic              hpLeftFromMixer,
  input wire logic              hpRightFromMixer
);
  localparam logic [7:0] ATT_T [4] = '{8'h00, 8'h3c, 8'h5f, 8'h78};
  logic [15:0] holdCnt;
  logic        wrAcc;
  assign wrAcc = psel && penable && pwrite && pstrb[0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Cycles already spent in the hold, for an exact length check
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) holdCnt <= 16'h0000;
    else if (spkLeftShutdown) holdCnt <= holdCnt + 16'h0001;
    else holdCnt <= 16'h0000;
  end
  AST_BRIDGE: assert property (lineBridged |-> lineRightSources == lineLeftSources
    && lineRightAtt == lineLeftAtt && lineRightVolCode == lineLeftVolCode)
    else $error("Right line path differs from left in bridged mode");
  AST_MODE_BIT: assert property (wrAcc && paddr == {IDX_LINE_MIX_R, 2'b00}
    |=> lineBridged == !$past(pwdata[BIT_MODE])) else $error("Mode bit not applied");
  AST_LINE_GAIN: assert property (wrAcc && paddr == {IDX_LINE_GAIN_R, 2'b00} && !lineBridged
    |=> lineRightAtt == ATT_T[$past(pwdata[1:0])]) else $error("Line gain decode wrong");
  AST_SPK_VOL: assert property (wrAcc && paddr == {IDX_SPK_VOL_L, 2'b00}
    |=> spkLeftVolCode == $past(pwdata[5:0]) && spkLeftMute == $past(pwdata[7]))
    else $error("Speaker volume write not applied");
  AST_HP_SEL: assert property (wrAcc && paddr == {IDX_HP_SEL_GAIN, 2'b00}
    |=> hpLeftFromMixer == $past(pwdata[4]) && hpRightFromMixer == $past(pwdata[5]))
    else $error("Headphone select not applied");
  AST_TRIP: assert property (thermFaultLeft [*6] |-> !spkLeftEnable)
    else $error("Speaker still enabled under fault");
  AST_HOLD_LEN: assert property ($fell(spkLeftShutdown) |-> holdCnt == RETRY_CYCLES)
    else $error("Shutdown hold length wrong");
  AST_HOLD_OFF: assert property (spkLeftShutdown |-> !spkLeftEnable
    && holdCnt < RETRY_CYCLES) else $error("Speaker on during hold");
  AST_FOLLOW: assert property (spkRightClockFromLeft |-> spkLeftEnable && spkRightEnable)
    else $error("Clock follow without both channels on");
  AST_RD_UPPER: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("Upper read bits not zero");
endmodule
bind aopc_top aopc_props #(.RETRY_CYCLES(RETRY_CYCLES)) u_props (.sys_clk, .rst_n, .paddr,
  .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .thermFaultLeft, .lineBridged,
  .lineLeftSources, .lineRightSources, .lineLeftAtt, .lineRightAtt, .lineLeftVolCode,
  .lineRightVolCode, .spkLeftVolCode, .spkLeftMute, .spkLeftEnable, .spkRightEnable,
  .spkRightClockFromLeft, .spkLeftShutdown, .hpLeftFromMixer, .hpRightFromMixer);

// ===== tb/aopc_top_bench.sv
// Purpose: Self-checking bench for the output path control register bank
// Assumes: APB slave, short retry hold of 8 cycles
// Notes:   Reads are scored through a queue by a monitor process
`timescale 1ns/10ps
module aopc_top_bench;
  import aopc_pkg::*;
  localparam int RETRY = 8;
  localparam logic [7:0] ATT [4] = '{8'h00, 8'h3c, 8'h5f, 8'h78};
  localparam logic [7:0] IDX_T [14] = '{IDX_HP_MIX_L, IDX_HP_MIX_R, IDX_HP_SEL_GAIN,
    IDX_SPK_MIX_L, IDX_SPK_MIX_R, IDX_SPK_GAIN, IDX_SPK_VOL_L, IDX_SPK_VOL_R, IDX_LINE_MIX_L,
    IDX_LINE_GAIN_L, IDX_LINE_VOL_L, IDX_LINE_MIX_R, IDX_LINE_GAIN_R, IDX_LINE_VOL_R};
  localparam logic [7:0] MSK_T [14] = '{8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h7f, 8'h0f, 8'hbf,
    8'hbf, 8'h3f, 8'h03, 8'h9f, 8'hbf, 8'h03, 8'h9f};
  localparam logic [7:0] RST_T [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2c,
    8'h2c, 8'h00, 8'h00, 8'h15, 8'h00, 8'h00, 8'h15};
  localparam logic [5:0] SV [3] = '{6'h3f, 6'h2c, 6'h18};
  localparam logic [4:0] LV [3] = '{5'h1f, 5'h15, 5'h00};
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, lineBridged;
  logic        spkLeftEnableReq, spkRightEnableReq, thermFaultLeft, thermFaultRight;
  logic        lineLeftMute, lineRightMute, spkLeftMute, spkRightMute, spkLeftEnable;
  logic        spkRightEnable, spkRightClockFromLeft, spkLeftShutdown, spkRightShutdown;
  logic        hpLeftFromMixer, hpRightFromMixer;
  logic [9:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata;
  logic [5:0]  lineLeftSources, lineRightSources, spkLeftSources, spkRightSources;
  logic [5:0]  spkLeftVolCode, spkRightVolCode, hpLeftSources, hpRightSources;
  logic [7:0]  lineLeftAtt, lineRightAtt, spkLeftAtt, spkRightAtt, hpLeftAtt, hpRightAtt;
  logic [4:0]  lineLeftVolCode, lineRightVolCode;
  logic [32:0] expQ [$];
  int          fail_count = 0;
  int          checked = 0;
  int          seed = 36555;
  aopc_top #(.RETRY_CYCLES(RETRY)) dut (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .spkLeftEnableReq, .spkRightEnableReq,
    .thermFaultLeft, .thermFaultRight, .lineBridged, .lineLeftSources, .lineRightSources,
    .lineLeftAtt, .lineRightAtt, .lineLeftVolCode, .lineRightVolCode, .lineLeftMute,
    .lineRightMute, .spkLeftSources, .spkRightSources, .spkLeftAtt, .spkRightAtt,
    .spkLeftVolCode, .spkRightVolCode, .spkLeftMute, .spkRightMute, .spkLeftEnable,
    .spkRightEnable, .spkRightClockFromLeft, .spkLeftShutdown, .spkRightShutdown,
    .hpLeftSources, .hpRightSources, .hpLeftAtt, .hpRightAtt, .hpLeftFromMixer,
    .hpRightFromMixer);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk_read(input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] read expected %h seen %h", e, g);
    end
  endtask
  task automatic pc(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [32:0] e);
    int r;
    int n;
    r = $random(seed);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    // Random upper bits must be dropped by the bank
    pwdata <= {r[23:0], d};
    if (!wr) expQ.push_back(e);
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never re-drives psel in this step
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 8'h00, {25'h0, e});
  endtask
  task automatic final_report;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1)
      chk_read(expQ.pop_front(), {pslverr, prdata});
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    final_report;
  end
  initial begin
    logic [7:0] v;
    logic [1:0] g;
    int         r;
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {spkLeftEnableReq, spkRightEnableReq, thermFaultLeft, thermFaultRight} = 4'h0;
    pstrb = 4'hf;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) rd(IDX_T[i], RST_T[i]);
    for (int i = 0; i < 14; i++) begin
      v = 8'($random(seed));
      wr(IDX_T[i], v);
      rd(IDX_T[i], v & MSK_T[i]);
    end
    apb(1'b0, 10'h000, 8'h00, {1'b1, 32'h0});
    apb(1'b0, 10'h0a5, 8'h00, {1'b1, 32'h0});
    wr(IDX_HP_MIX_L, 8'h00);
    pstrb <= 4'h0;
    wr(IDX_HP_MIX_L, 8'h3f);
    pstrb <= 4'hf;
    rd(IDX_HP_MIX_L, 8'h00);
    $display("test registers finished");
    wr(IDX_LINE_MIX_L, 8'h15);
    wr(IDX_LINE_GAIN_L, 8'h02);
    wr(IDX_LINE_VOL_L, 8'h8a);
    wr(IDX_LINE_MIX_R, 8'h2a);
    wr(IDX_LINE_GAIN_R, 8'h01);
    wr(IDX_LINE_VOL_R, 8'h03);
    @(posedge sys_clk);
    pc("lineBridged", 8'h01, 8'(lineBridged));
    pc("lineRightSources", 8'h15, 8'(lineRightSources));
    pc("lineRightAtt", 8'h5f, lineRightAtt);
    pc("lineRightVolCode", 8'h0a, 8'(lineRightVolCode));
    pc("lineRightMute", 8'h01, 8'(lineRightMute));
    pc("lineLeftVolCode", 8'h0a, 8'(lineLeftVolCode));
    pc("lineLeftMute", 8'h01, 8'(lineLeftMute));
    pc("lineLeftAtt", 8'h5f, lineLeftAtt);
    wr(IDX_LINE_MIX_R, 8'haa);
    @(posedge sys_clk);
    pc("lineBridged", 8'h00, 8'(lineBridged));
    pc("lineRightSources", 8'h2a, 8'(lineRightSources));
    pc("lineRightAtt", 8'h3c, lineRightAtt);
    pc("lineRightVolCode", 8'h03, 8'(lineRightVolCode));
    pc("lineRightMute", 8'h00, 8'(lineRightMute));
    pc("lineLeftSources", 8'h15, 8'(lineLeftSources));
    $display("test bridged finished");
    for (int k = 0; k < 4; k++) begin
      g = k[1:0];
      r = $random(seed);
      wr(IDX_LINE_GAIN_R, {6'h0, g});
      wr(IDX_SPK_GAIN, {4'h0, g, ~g});
      wr(IDX_HP_SEL_GAIN, {2'b00, g[0], g[1], g, ~g});
      wr(IDX_SPK_MIX_L, r[7:0]);
      wr(IDX_SPK_MIX_R, r[15:8]);
      wr(IDX_HP_MIX_L, r[23:16]);
      wr(IDX_HP_MIX_R, r[31:24]);
      @(posedge sys_clk);
      pc("lineRightAtt", ATT[g], lineRightAtt);
      pc("spkRightAtt", ATT[g], spkRightAtt);
      pc("spkLeftAtt", ATT[~g], spkLeftAtt);
      pc("hpRightAtt", ATT[g], hpRightAtt);
      pc("hpLeftAtt", ATT[~g], hpLeftAtt);
      pc("hpRightFromMixer", 8'(g[0]), 8'(hpRightFromMixer));
      pc("hpLeftFromMixer", 8'(g[1]), 8'(hpLeftFromMixer));
      pc("spkLeftSources", 8'(r[5:0]), 8'(spkLeftSources));
      pc("spkRightSources", 8'(r[13:8]), 8'(spkRightSources));
      pc("hpLeftSources", 8'(r[21:16]), 8'(hpLeftSources));
      pc("hpRightSources", 8'(r[29:24]), 8'(hpRightSources));
    end
    $display("test gains finished");
    for (int k = 0; k < 3; k++) begin
      wr(IDX_SPK_VOL_L, {k[0], 1'b0, SV[k]});
      wr(IDX_SPK_VOL_R, {~k[0], 1'b0, SV[k]});
      wr(IDX_LINE_VOL_R, {k[0], 2'b00, LV[k]});
      @(posedge sys_clk);
      pc("spkLeftVolCode", 8'(SV[k]), 8'(spkLeftVolCode));
      pc("spkRightVolCode", 8'(SV[k]), 8'(spkRightVolCode));
      pc("spkLeftMute", 8'(k[0]), 8'(spkLeftMute));
      pc("spkRightMute", {7'h0, ~k[0]}, 8'(spkRightMute));
      pc("lineRightVolCode", 8'(LV[k]), 8'(lineRightVolCode));
    end
    $display("test volumes finished");
    wr(IDX_SPK_MIX_R, 8'h40);
    spkLeftEnableReq <= 1'b1;
    spkRightEnableReq <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pc("spkRightClockFromLeft", 8'h01, 8'(spkRightClockFromLeft));
    thermFaultLeft <= 1'b1;
    thermFaultRight <= 1'b1;
    repeat (6) @(posedge sys_clk);
    pc("spkLeftEnable", 8'h00, 8'(spkLeftEnable));
    pc("spkRightEnable", 8'h00, 8'(spkRightEnable));
    pc("spkLeftShutdown", 8'h01, 8'(spkLeftShutdown));
    pc("spkRightClockFromLeft", 8'h00, 8'(spkRightClockFromLeft));
    // Fault still present past one hold: must trip again
    repeat (RETRY + 12) @(posedge sys_clk);
    pc("spkLeftEnable", 8'h00, 8'(spkLeftEnable));
    {thermFaultLeft, thermFaultRight} <= 2'b00;
    repeat (2 * RETRY + 12) @(posedge sys_clk);
    pc("spkLeftEnable", 8'h01, 8'(spkLeftEnable));
    pc("spkRightShutdown", 8'h00, 8'(spkRightShutdown));
    wr(IDX_SPK_MIX_R, 8'h00);
    @(posedge sys_clk);
    pc("spkRightClockFromLeft", 8'h00, 8'(spkRightClockFromLeft));
    $display("test thermal finished");
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(IDX_SPK_VOL_L, 8'h2c);
    rd(IDX_LINE_MIX_R, 8'h00);
    repeat (2) @(posedge sys_clk);
    $display("test second reset finished");
    final_report;
  end
endmodule
